/* dlag_pkg.sv */
// package: timing constants and types for the leveling/alert/geardown link
package dlag_pkg;
    localparam int unsigned CLK_PERIOD_PS = 20000;
    localparam int unsigned LEVEL_FIRST_STROBE_NCK = 40;
    localparam int unsigned LEVEL_STROBE_ENABLE_NCK = 25;
    localparam int unsigned PARITY_LATENCY_NCK = 5;
    localparam int unsigned PARITY_ALERT_EXTRA_PS = 6000;
    localparam int unsigned PARITY_ALERT_PW_MIN_NCK = 80;
    localparam int unsigned PARITY_ALERT_PW_MAX_NCK = 160;
    localparam int unsigned PARITY_DESELECT_RESPONSE_NCK = 71;
    localparam int unsigned CRC_ALERT_LAT_MIN_PS = 3000;
    localparam int unsigned CRC_ALERT_LAT_MAX_PS = 13000;
    localparam int unsigned CRC_ALERT_PULSE_WIDTH_MIN_NCK = 6;
    localparam int unsigned CRC_ALERT_PULSE_WIDTH_MAX_NCK = 10;
    localparam int unsigned RESET_EXIT_TIME_NCK = 16;
    localparam int unsigned SELFREFRESH_EXIT_TIME_NCK = 16;
    localparam int unsigned MODE_REGISTER_UPDATE_DELAY_NCK = 24;
    localparam int unsigned GEARDOWN_MARGIN_NCK = 4;
    localparam int unsigned GEAR_SETUP_NCK = 2;
    localparam int unsigned GEAR_HOLD_NCK = 2;
    // longest delay rounds down, at least one cycle
    localparam int unsigned PARITY_ALERT_DELAY_NCK =
        PARITY_LATENCY_NCK + ((PARITY_ALERT_EXTRA_PS / CLK_PERIOD_PS) > 0 ?
        (PARITY_ALERT_EXTRA_PS / CLK_PERIOD_PS) : 0);
    localparam int unsigned CRC_ALERT_DELAY_NCK =
        (CRC_ALERT_LAT_MAX_PS / CLK_PERIOD_PS) > 0 ? (CRC_ALERT_LAT_MAX_PS / CLK_PERIOD_PS) : 1;
    localparam int unsigned CNT_W = 8;
    typedef enum logic [1:0] {DLAG_ALERT_IDLE, DLAG_ALERT_WAIT, DLAG_ALERT_PULSE} dlag_alert_type;
    typedef enum logic [2:0] {DLAG_CT_IDLE, DLAG_CT_LEVEL, DLAG_CT_STROBE, DLAG_CT_EXITW, DLAG_CT_GEARW,
        DLAG_CT_SYNC, DLAG_CT_CMDW, DLAG_CT_PARDES} dlag_ctl_type;
    function automatic logic [CNT_W-1:0] dlag_even(input int unsigned n);
        dlag_even = CNT_W'(n + (n % 2));
    endfunction
endpackage

/* dlag_link_if.sv */
// interface: command, strobe, sync and alert wires between controller and device
`timescale 1ns/1ps
`default_nettype none
interface dlag_link_if;
    logic mrs_level;
    logic mrs_gear;
    logic cke;
    logic selfref_exit;
    logic strobe_drive;
    logic strobe_rise;
    logic sync_pulse;
    logic cmd_valid;
    logic deselect;
    logic parity_error;
    logic crc_error;
    logic alert_n_o;
    logic alert_n_oe;
    wire logic alert_n_line = alert_n_oe ? alert_n_o : 1'b1;
    modport dev (input mrs_level, mrs_gear, cke, selfref_exit, strobe_drive, strobe_rise, sync_pulse,
        cmd_valid, deselect, parity_error, crc_error, output alert_n_o, alert_n_oe);
    // error strobes are injected from the test side; neither end drives them
    modport ctl (output mrs_level, mrs_gear, cke, selfref_exit, strobe_drive, strobe_rise, sync_pulse,
        cmd_valid, deselect, input alert_n_line);
endinterface
`default_nettype wire

/* dlag_device.sv */
// device end: parity and crc alert pulse generation
`timescale 1ns/1ps
`default_nettype none
module dlag_device
    import dlag_pkg::*;
#(
    parameter int unsigned PARITY_PW = PARITY_ALERT_PW_MIN_NCK,
    parameter int unsigned CRC_PW = CRC_ALERT_PULSE_WIDTH_MIN_NCK
) (
    input wire logic mclk_i,        // 50 MHz clock
    input wire logic reset_n_i,     // sync reset, active low
    dlag_link_if.dev link,          // link to controller
    output logic exec_blocked_o,    // commands not guaranteed executed
    output logic parity_alert_o,    // parity alert pulse active
    output logic crc_alert_o        // crc alert pulse active
);
    dlag_alert_type st_q, st_d;
    logic is_par_q, is_par_d;
    logic [CNT_W-1:0] cnt_q, cnt_d, blk_q, blk_d;
    logic alert_q, alert_d;

    always_comb begin
        st_d = st_q;
        is_par_d = is_par_q;
        cnt_d = cnt_q;
        alert_d = 1'b0;
        blk_d = (blk_q != '0) ? blk_q - 1'b1 : '0;
        case (st_q)
            DLAG_ALERT_IDLE: begin
                if (link.parity_error) begin
                    st_d = DLAG_ALERT_WAIT;
                    is_par_d = 1'b1;
                    cnt_d = CNT_W'(PARITY_ALERT_DELAY_NCK - 1);
                    blk_d = CNT_W'(PARITY_LATENCY_NCK);
                end else if (link.crc_error) begin
                    st_d = DLAG_ALERT_WAIT;
                    is_par_d = 1'b0;
                    cnt_d = CNT_W'(CRC_ALERT_DELAY_NCK - 1);
                end
            end
            DLAG_ALERT_WAIT: begin
                if (cnt_q == '0) begin
                    st_d = DLAG_ALERT_PULSE;
                    alert_d = 1'b1;
                    cnt_d = is_par_q ? CNT_W'(PARITY_PW - 1) : CNT_W'(CRC_PW - 1);
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            DLAG_ALERT_PULSE: begin
                if (cnt_q == '0) begin
                    st_d = DLAG_ALERT_IDLE;
                end else begin
                    alert_d = 1'b1;
                    cnt_d = cnt_q - 1'b1;
                end
            end
            default: st_d = DLAG_ALERT_IDLE;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            st_q <= DLAG_ALERT_IDLE;
            is_par_q <= 1'b0;
            cnt_q <= '0;
            blk_q <= '0;
            alert_q <= 1'b0;
            exec_blocked_o <= 1'b0;
            parity_alert_o <= 1'b0;
            crc_alert_o <= 1'b0;
        end else begin
            st_q <= st_d;
            is_par_q <= is_par_d;
            cnt_q <= cnt_d;
            blk_q <= blk_d;
            alert_q <= alert_d;
            exec_blocked_o <= (blk_d != '0);
            parity_alert_o <= alert_d & is_par_d;
            crc_alert_o <= alert_d & ~is_par_d;
        end
    end

    // open drain: drive low only during pulse, release otherwise
    assign link.alert_n_o = 1'b0;
    assign link.alert_n_oe = alert_q;
endmodule
`default_nettype wire

/* dlag_controller.sv */
// controller end: leveling, parity deselect and geardown sequencing
`timescale 1ns/1ps
`default_nettype none
module dlag_controller
    import dlag_pkg::*;
(
    input wire logic mclk_i,         // 50 MHz clock
    input wire logic reset_n_i,      // sync reset, active low
    dlag_link_if.ctl link,           // link to device
    input wire logic level_req_i,    // start write leveling
    input wire logic gear_req_i,     // start geardown entry
    input wire logic from_sr_i,      // geardown after self refresh exit
    input wire logic persistent_i,   // persistent parity mode
    output logic busy_o,             // sequence running
    output logic alert_seen_o        // synchronised alert level
);
    dlag_ctl_type st_q, st_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic mrs_level_q, mrs_level_d, mrs_gear_q, mrs_gear_d, cke_q, cke_d, sr_q, sr_d;
    logic sdrv_q, sdrv_d, srise_q, srise_d, sync_q, sync_d, cmd_q, cmd_d, des_q, des_d, srx_q, srx_d;
    logic al1_q, al2_q, al3_q, alert_q, alert_d;

    // three-stage sampler for the shared alert line; change when 2 and 3 agree
    always_comb begin
        alert_d = alert_q;
        if (al2_q == al3_q) begin
            alert_d = ~al3_q;
        end
    end

    always_comb begin
        st_d = st_q;
        cnt_d = (cnt_q != '0) ? cnt_q - 1'b1 : '0;
        mrs_level_d = 1'b0;
        mrs_gear_d = 1'b0;
        srise_d = 1'b0;
        cmd_d = 1'b0;
        cke_d = cke_q;
        sr_d = 1'b0;
        sdrv_d = sdrv_q;
        sync_d = sync_q;
        des_d = des_q;
        srx_d = srx_q;
        case (st_q)
            DLAG_CT_IDLE: begin
                cke_d = 1'b1;
                if (alert_q && persistent_i) begin
                    st_d = DLAG_CT_PARDES;
                    des_d = 1'b1;
                end else if (level_req_i) begin
                    st_d = DLAG_CT_LEVEL;
                    mrs_level_d = 1'b1;
                    cnt_d = CNT_W'(LEVEL_STROBE_ENABLE_NCK);
                end else if (gear_req_i) begin
                    st_d = DLAG_CT_EXITW;
                    srx_d = from_sr_i;
                    sr_d = from_sr_i;
                    cnt_d = from_sr_i ? CNT_W'(SELFREFRESH_EXIT_TIME_NCK) : CNT_W'(RESET_EXIT_TIME_NCK);
                end
            end
            DLAG_CT_LEVEL: begin
                if (cnt_q == '0) begin
                    sdrv_d = 1'b1;
                    st_d = DLAG_CT_STROBE;
                    cnt_d = CNT_W'(LEVEL_FIRST_STROBE_NCK - LEVEL_STROBE_ENABLE_NCK);
                end
            end
            DLAG_CT_STROBE: begin
                if (cnt_q == '0) begin
                    srise_d = 1'b1;
                    sdrv_d = 1'b0;
                    st_d = DLAG_CT_IDLE;
                end
            end
            DLAG_CT_EXITW: begin
                if (cnt_q == '0) begin
                    mrs_gear_d = 1'b1;
                    st_d = DLAG_CT_GEARW;
                    // sync edge lands after setup lead, leaving whole even interval
                    cnt_d = dlag_even(MODE_REGISTER_UPDATE_DELAY_NCK + GEARDOWN_MARGIN_NCK) -
                        CNT_W'(GEAR_SETUP_NCK);
                end
            end
            DLAG_CT_GEARW: begin
                if (cnt_q == '0) begin
                    sync_d = 1'b1;
                    st_d = DLAG_CT_SYNC;
                    cnt_d = CNT_W'(GEAR_SETUP_NCK + GEAR_HOLD_NCK);
                end
            end
            DLAG_CT_SYNC: begin
                if (cnt_q == '0) begin
                    sync_d = 1'b0;
                    st_d = DLAG_CT_CMDW;
                    cnt_d = dlag_even(MODE_REGISTER_UPDATE_DELAY_NCK) - CNT_W'(GEAR_HOLD_NCK);
                end
            end
            DLAG_CT_CMDW: begin
                if (cnt_q == '0) begin
                    cmd_d = 1'b1;
                    srx_d = 1'b0;
                    st_d = DLAG_CT_IDLE;
                end
            end
            DLAG_CT_PARDES: begin
                if (!alert_q) begin
                    des_d = 1'b0;
                    st_d = DLAG_CT_IDLE;
                end
            end
            default: st_d = DLAG_CT_IDLE;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            st_q <= DLAG_CT_IDLE;
            cnt_q <= '0;
            {mrs_level_q, mrs_gear_q, cke_q, sr_q, sdrv_q, srise_q} <= '0;
            {sync_q, cmd_q, des_q, srx_q} <= '0;
            {al1_q, al2_q, al3_q, alert_q} <= 4'h7 << 1;
            busy_o <= 1'b0;
            alert_seen_o <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            mrs_level_q <= mrs_level_d;
            mrs_gear_q <= mrs_gear_d;
            cke_q <= cke_d;
            sr_q <= sr_d;
            sdrv_q <= sdrv_d;
            srise_q <= srise_d;
            sync_q <= sync_d;
            cmd_q <= cmd_d;
            des_q <= des_d;
            srx_q <= srx_d;
            al1_q <= link.alert_n_line;
            al2_q <= al1_q;
            al3_q <= al2_q;
            alert_q <= alert_d;
            busy_o <= (st_d != DLAG_CT_IDLE);
            alert_seen_o <= alert_d;
        end
    end

    assign link.mrs_level = mrs_level_q;
    assign link.mrs_gear = mrs_gear_q;
    assign link.cke = cke_q;
    assign link.selfref_exit = sr_q;
    assign link.strobe_drive = sdrv_q;
    assign link.strobe_rise = srise_q;
    assign link.sync_pulse = sync_q;
    assign link.cmd_valid = cmd_q;
    assign link.deselect = des_q;
endmodule
`default_nettype wire

/* dlag_link_monitor.sv */
// checker: timing relations on the leveling/alert/geardown link
`timescale 1ns/1ps
`default_nettype none
module dlag_link_monitor
    import dlag_pkg::*;
(
    input wire logic mclk_i,       // clock
    input wire logic reset_n_i,    // sync reset
    input wire logic mrs_level,    // leveling mrs
    input wire logic mrs_gear,     // geardown mrs
    input wire logic cke,          // clock enable
    input wire logic selfref_exit, // self refresh exit
    input wire logic strobe_drive, // strobe driven
    input wire logic strobe_rise,  // first strobe edge
    input wire logic sync_pulse,   // geardown sync
    input wire logic cmd_valid,    // first command
    input wire logic parity_error, // parity error
    input wire logic crc_error,    // crc error
    input wire logic alert_n_o,    // alert value
    input wire logic alert_n_oe    // alert enable
);
    logic [7:0] lv_q, gr_q, sy_q, ex_q, pw_q;
    logic sync_q;
    // saturate so a long idle never wraps into a short interval
    function automatic logic [7:0] inc(input logic [7:0] v);
        return (v == 8'hff) ? v : v + 8'h01;
    endfunction
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            lv_q <= 8'h00;
            gr_q <= 8'h00;
            sy_q <= 8'h00;
            ex_q <= 8'h00;
            pw_q <= 8'h00;
            sync_q <= 1'b0;
        end else begin
            lv_q <= mrs_level ? 8'h01 : inc(lv_q);
            gr_q <= mrs_gear ? 8'h01 : inc(gr_q);
            sy_q <= (sync_pulse && !sync_q) ? 8'h01 : inc(sy_q);
            ex_q <= (!cke || selfref_exit) ? 8'h00 : inc(ex_q);
            pw_q <= alert_n_oe ? inc(pw_q) : 8'h00;
            sync_q <= sync_pulse;
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);
    a_first_strobe_wait: assert property (strobe_rise |-> lv_q >= LEVEL_FIRST_STROBE_NCK)
        else $error("strobe edge too early");
    a_strobe_enable_wait: assert property ($rose(strobe_drive) |-> lv_q >= LEVEL_STROBE_ENABLE_NCK)
        else $error("strobe driven too early");
    a_parity_alert_latency: assert property (parity_error && !alert_n_oe |-> ##[1:6] $rose(alert_n_oe))
        else $error("parity alert late");
    a_crc_alert_latency: assert property (crc_error && !parity_error && !alert_n_oe |-> ##[1:2] $rose(alert_n_oe))
        else $error("crc alert late");
    a_alert_pulse_width: assert property ($fell(alert_n_oe) |->
        (pw_q >= PARITY_ALERT_PW_MIN_NCK && pw_q <= PARITY_ALERT_PW_MAX_NCK) ||
        (pw_q >= CRC_ALERT_PULSE_WIDTH_MIN_NCK && pw_q <= CRC_ALERT_PULSE_WIDTH_MAX_NCK)) else $error("alert width wrong");
    a_alert_low_drive: assert property (alert_n_oe |-> !alert_n_o)
        else $error("alert driven high");
    a_gear_exit_wait: assert property (mrs_gear |-> ex_q >= RESET_EXIT_TIME_NCK)
        else $error("geardown mrs too soon after exit");
    a_sync_after_mrs: assert property ($rose(sync_pulse) |->
        gr_q + GEAR_SETUP_NCK >= MODE_REGISTER_UPDATE_DELAY_NCK + GEARDOWN_MARGIN_NCK) else $error("sync early");
    a_sync_hold_time: assert property ($rose(sync_pulse) |-> sync_pulse[*4])
        else $error("sync too short");
    a_first_cmd_wait: assert property (cmd_valid |-> sy_q >= MODE_REGISTER_UPDATE_DELAY_NCK)
        else $error("command too soon after sync");
    c_strobe: cover property (strobe_rise);
    c_alert_end: cover property ($fell(alert_n_oe));
    c_first_cmd: cover property (cmd_valid);
endmodule
`default_nettype wire

/* tb.sv */
// testbench: both link ends joined, sequences and alert pulses checked
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_errors++; $display("BAD %0t mismatch line %0d", $time, `__LINE__); end end
module tb;
    import dlag_pkg::*;
    logic mclk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic level_req_i = 1'b0, gear_req_i = 1'b0, from_sr_i = 1'b0, persistent_i = 1'b0;
    logic busy_o, alert_seen_o, exec_blocked_o, parity_alert_o, crc_alert_o;
    int n_errors = 0;
    int check_count = 0;
    int cyc = 0;
    int t_ml, t_sd, t_sr, t_mg, t_sx, t_sy, t_sf, t_cv, t_al, t_ds, t_err, t_rel, n_lo, n_pa, n_cr, n_xb;
    int n_as, n_bs, t0;
    logic sy_d = 1'b0, sd_d = 1'b0, al_d = 1'b1, ds_d = 1'b0;
    dlag_link_if link();
    dlag_device i_dlag_device(.mclk_i(mclk_i), .reset_n_i(reset_n_i), .link(link),
        .exec_blocked_o(exec_blocked_o), .parity_alert_o(parity_alert_o), .crc_alert_o(crc_alert_o));
    dlag_controller i_dlag_controller(.mclk_i(mclk_i), .reset_n_i(reset_n_i), .link(link),
        .level_req_i(level_req_i), .gear_req_i(gear_req_i), .from_sr_i(from_sr_i),
        .persistent_i(persistent_i), .busy_o(busy_o), .alert_seen_o(alert_seen_o));
    dlag_link_monitor i_dlag_link_monitor(.mclk_i(mclk_i), .reset_n_i(reset_n_i), .mrs_level(link.mrs_level),
        .mrs_gear(link.mrs_gear), .cke(link.cke), .selfref_exit(link.selfref_exit),
        .strobe_drive(link.strobe_drive), .strobe_rise(link.strobe_rise), .sync_pulse(link.sync_pulse),
        .cmd_valid(link.cmd_valid), .parity_error(link.parity_error), .crc_error(link.crc_error),
        .alert_n_o(link.alert_n_o), .alert_n_oe(link.alert_n_oe));
    always #10 mclk_i = ~mclk_i;
    // timestamps of link events, in sampling edges
    always @(posedge mclk_i) begin
        cyc++;
        if (reset_n_i !== 1'b1) t_rel = cyc;
        if (link.mrs_level === 1'b1) t_ml = cyc;
        if (link.strobe_drive === 1'b1 && !sd_d) t_sd = cyc;
        if (link.strobe_rise === 1'b1) t_sr = cyc;
        if (link.mrs_gear === 1'b1) t_mg = cyc;
        if (link.selfref_exit === 1'b1) t_sx = cyc;
        if (link.sync_pulse === 1'b1 && !sy_d) t_sy = cyc;
        if (link.sync_pulse === 1'b0 && sy_d) t_sf = cyc;
        if (link.cmd_valid === 1'b1) t_cv = cyc;
        if (link.alert_n_line === 1'b0 && al_d) t_al = cyc;
        if (link.deselect === 1'b1 && !ds_d) t_ds = cyc;
        if (link.parity_error === 1'b1 || link.crc_error === 1'b1) t_err = cyc;
        n_lo += (link.alert_n_line === 1'b0);
        n_pa += (parity_alert_o === 1'b1);
        n_cr += (crc_alert_o === 1'b1);
        n_xb += (exec_blocked_o === 1'b1);
        n_as += (alert_seen_o === 1'b1);
        n_bs += (busy_o === 1'b1);
        sd_d = (link.strobe_drive === 1'b1);
        sy_d = (link.sync_pulse === 1'b1);
        al_d = (link.alert_n_line !== 1'b0);
        ds_d = (link.deselect === 1'b1);
    end
    task automatic final_report();
        if (n_errors == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
    endtask
    // bounded wait until the controller is idle and the alert line is back
    task automatic quiet(input int lim);
        int i;
        tick(3);
        for (i = 0; i < lim; i++) begin
            @(posedge mclk_i);
            if (busy_o === 1'b0 && link.alert_n_line === 1'b1 && alert_seen_o === 1'b0) break;
        end
        tick(2);
        if (i == lim) begin
            n_errors++;
            $display("BAD %0t wait ran out", $time);
            final_report();
        end
    endtask
    // alert comes some cycles after the error; quiet alone would see the idle line first
    task automatic wait_alert(input int lim);
        int i;
        for (i = 0; i < lim; i++) begin
            @(posedge mclk_i);
            if (link.alert_n_line === 1'b0) break;
        end
        if (i == lim) begin
            n_errors++;
            $display("BAD %0t alert never came", $time);
            final_report();
        end
    endtask
    task automatic t_level();
        t0 = cyc;
        n_bs = 0;
        level_req_i <= 1'b1;
        tick(1);
        level_req_i <= 1'b0;
        quiet(300);
        `CHK(t_ml > t0 && t_sd > t_ml && t_sd - t_ml >= LEVEL_STROBE_ENABLE_NCK, 1'b1)
        `CHK(t_sr > t_sd && t_sr - t_ml >= LEVEL_FIRST_STROBE_NCK, 1'b1)
        `CHK(n_bs >= LEVEL_FIRST_STROBE_NCK, 1'b1)
    endtask
    task automatic t_parity(input logic pers);
        t0 = cyc;
        persistent_i <= pers;
        n_lo = 0;
        n_pa = 0;
        n_xb = 0;
        n_as = 0;
        link.parity_error <= 1'b1;
        tick(1);
        link.parity_error <= 1'b0;
        wait_alert(20);
        quiet(400);
        persistent_i <= 1'b0;
        `CHK(n_xb, PARITY_LATENCY_NCK)
        `CHK(t_err > t0 && t_al > t_err && t_al - t_err <= PARITY_LATENCY_NCK + 1, 1'b1)
        `CHK(n_as, n_lo)
        `CHK(n_lo >= PARITY_ALERT_PW_MIN_NCK && n_lo <= PARITY_ALERT_PW_MAX_NCK, 1'b1)
        `CHK(n_pa, n_lo)
        `CHK(link.alert_n_line, 1'b1)
        if (pers) `CHK(t_ds > t_al && t_ds - t_al <= PARITY_DESELECT_RESPONSE_NCK, 1'b1)
    endtask
    task automatic t_crc();
        t0 = cyc;
        n_lo = 0;
        n_cr = 0;
        link.crc_error <= 1'b1;
        tick(1);
        link.crc_error <= 1'b0;
        wait_alert(10);
        quiet(100);
        `CHK(t_err > t0 && t_al > t_err && t_al - t_err <= 2, 1'b1)
        `CHK(n_lo >= CRC_ALERT_PULSE_WIDTH_MIN_NCK && n_lo <= CRC_ALERT_PULSE_WIDTH_MAX_NCK, 1'b1)
        `CHK(n_cr, n_lo)
    endtask
    task automatic t_gear(input logic sr);
        t0 = cyc;
        from_sr_i <= sr;
        gear_req_i <= 1'b1;
        tick(1);
        gear_req_i <= 1'b0;
        quiet(300);
        `CHK(t_mg > t0 && t_sy > t_mg && t_sf > t_sy && t_cv > t_sf, 1'b1)
        `CHK(!sr || (t_sx > t0 && t_sx < t_mg), 1'b1)
        `CHK(t_mg - (sr ? t_sx : t_rel) >= (sr ? SELFREFRESH_EXIT_TIME_NCK : RESET_EXIT_TIME_NCK), 1'b1)
        `CHK(t_sy + GEAR_SETUP_NCK - t_mg >= MODE_REGISTER_UPDATE_DELAY_NCK + GEARDOWN_MARGIN_NCK, 1'b1)
        `CHK(t_sf - t_sy >= GEAR_SETUP_NCK + GEAR_HOLD_NCK, 1'b1)
        `CHK(t_cv - t_sy >= MODE_REGISTER_UPDATE_DELAY_NCK, 1'b1)
    endtask
    initial begin
        link.parity_error <= 1'b0;
        link.crc_error <= 1'b0;
        tick(4);
        reset_n_i <= 1'b1;
        tick(1);
        t_gear(1'b0);
        t_level();
        t_parity(1'b0);
        t_crc();
        t_parity(1'b1);
        t_gear(1'b1);
        final_report();
    end
endmodule
`default_nettype wire
